/* epls_link.sv */
// The implementer's own choice: the APB register port.
`default_nettype none
// Operation
// - FCS is reflected CRC-32, inverted
// - Start, preamble, payload, FCS, terminate
// - Gap averages twelve bytes
// - Deficit idle counter inserts or deletes idles
// - MAC makes FCS, keeps gap
// - Per-lane parity in alignment markers
// - Twenty virtual lanes onto ten physical
// - Bytes go least significant bit first
// - Error count zero after clear under lock
// - One clock-lock bit per lane
// - Flag select chooses reported FIFO flags
// - Alignment ready drops on marker lock loss
// - Alignment status bit follows ready output
// - Local fault on signal loss if enabled
// - Signal loss starts receive reset only
// - Receiver reorders lanes by lane tags
module epls_link import epls_pkg::*; #(
	parameter int VLANES = 20,
	parameter int PLANES = 10,
	parameter int TAG_W = 5,
	parameter int CNT_W = 32
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Transmit user stream
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_ready,
	// Transmit media-independent byte stream
	output logic [7:0] tx_byte,
	output logic tx_is_ctrl,
	// Receive status inputs
	input wire logic [PLANES-1:0] rx_cdr_lock,
	input wire logic rx_signal_ok,
	input wire logic rx_am_lock,
	input wire logic rx_ctrl_err,
	input wire logic rx_am_strobe,
	input wire logic [VLANES*TAG_W-1:0] rx_lane_tag,
	input wire logic [VLANES*8-1:0] rx_par_rcvd,
	input wire logic [VLANES*8-1:0] rx_par_calc,
	// Attachment FIFO flags
	input wire logic [PLANES-1:0] tx_fifo_full,
	input wire logic [PLANES-1:0] tx_fifo_empty,
	input wire logic [PLANES-1:0] rx_fifo_full,
	input wire logic [PLANES-1:0] rx_fifo_empty,
	// Receive status outputs
	output logic rx_align_ready,
	output logic local_fault,
	output logic rx_digital_reset,
	output logic [VLANES*TAG_W-1:0] rx_lane_map
);

	////////////////////////////////////////////////////////////////////////////
	// Reflected CRC step, bit 0 of the byte first
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			if (r[0] ^ b[i]) begin
				r = (r >> 1) ^ CRC_POLY_REFL;
			end else begin
				r = r >> 1;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Transmit framer
	epls_tx_state_t st_q;
	logic [31:0] crc_q;
	logic [2:0] cnt_q;
	logic [2:0] pos_q;
	logic [4:0] gap_q;
	logic [1:0] debt_q;
	logic [31:0] fcs;
	logic start_ok;

	assign fcs = ~crc_q;
	// Borrowing up to three idles lets a start land on the lane boundary early
	assign start_ok = tx_valid && (pos_q == 3'((START_ALIGN) % 8)) &&
		({1'b0, gap_q} >= 6'(IPG_BYTES - IDLE_DEBT_MAX) + {4'h0, debt_q});

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= TX_IDLE;
			crc_q <= CRC_INIT;
			cnt_q <= 3'h0;
			pos_q <= 3'h0;
			gap_q <= 5'(IPG_BYTES);
			debt_q <= 2'h0;
			tx_ready <= 1'b0;
			tx_byte <= CH_IDLE;
			tx_is_ctrl <= 1'b1;
		end else begin
			pos_q <= pos_q + 3'h1;
			unique case (st_q)
				TX_IDLE: begin
					tx_is_ctrl <= 1'b1;
					if (start_ok) begin
						tx_byte <= CH_START;
						st_q <= TX_PRE;
						cnt_q <= 3'h0;
						crc_q <= CRC_INIT;
						// Debt grows by idles deleted, shrinks by idles added
						if ({1'b0, gap_q} >= 6'(IPG_BYTES) + {4'h0, debt_q}) begin
							debt_q <= 2'h0;
						end else begin
							debt_q <= 2'(6'(IPG_BYTES) + {4'h0, debt_q} - {1'b0, gap_q});
						end
					end else begin
						tx_byte <= CH_IDLE;
						if (gap_q != 5'h1f) begin
							gap_q <= gap_q + 5'h01;
						end
					end
				end
				TX_PRE: begin
					tx_is_ctrl <= 1'b0;
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == 3'(PRE_BYTES - 1)) begin
						tx_byte <= CH_SFD;
						st_q <= TX_DATA;
						tx_ready <= 1'b1;
					end else begin
						tx_byte <= CH_PRE;
					end
				end
				TX_DATA: begin
					if (tx_valid) begin
						tx_byte <= tx_data;
						tx_is_ctrl <= 1'b0;
						crc_q <= crc_step(crc_q, tx_data);
						if (tx_last) begin
							tx_ready <= 1'b0;
							st_q <= TX_FCS;
							cnt_q <= 3'h0;
						end
					end else begin
						// Underrun mid-frame cannot idle, so the frame is marked bad
						tx_byte <= CH_ERR;
						tx_is_ctrl <= 1'b1;
					end
				end
				TX_FCS: begin
					tx_is_ctrl <= 1'b0;
					tx_byte <= fcs[8*cnt_q[1:0] +: 8];
					cnt_q <= cnt_q + 3'h1;
					if (cnt_q == 3'(FCS_BYTES - 1)) begin
						st_q <= TX_TERM;
					end
				end
				TX_TERM: begin
					tx_is_ctrl <= 1'b1;
					tx_byte <= CH_TERM;
					gap_q <= 5'h01;
					st_q <= TX_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive link state
	logic sig_q;
	logic [7:0] rst_cnt_q;
	logic fault_en_q;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sig_q <= 1'b0;
			rst_cnt_q <= 8'h00;
			rx_digital_reset <= 1'b0;
		end else begin
			sig_q <= rx_signal_ok;
			// Only the receive path is reset; the framer runs on
			if (sig_q && !rx_signal_ok) begin
				rst_cnt_q <= 8'(RX_RST_CYC);
				rx_digital_reset <= 1'b1;
			end else if (rst_cnt_q != 8'h00) begin
				rst_cnt_q <= rst_cnt_q - 8'h01;
				rx_digital_reset <= (rst_cnt_q != 8'h01);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_align_ready <= 1'b0;
		end else begin
			rx_align_ready <= rx_am_lock && rx_signal_ok && !rx_digital_reset;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			local_fault <= 1'b0;
		end else begin
			local_fault <= fault_en_q && !rx_signal_ok;
		end
	end

	// Lane reorder map: entry t holds the arriving lane that carries tag t
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_lane_map <= '0;
		end else if (rx_am_strobe) begin
			for (int i = 0; i < VLANES; i++) begin
				rx_lane_map[TAG_W*int'(rx_lane_tag[TAG_W*i +: TAG_W]) +: TAG_W] <= TAG_W'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Status registers
	logic [PLANES-1:0] lock_q;
	logic [CNT_W-1:0] err_cnt_q;
	logic clr_q;
	logic [4:0] sel_q;
	logic [1:0] flags_q;
	logic [PLANES-1:0] par_err_q;
	logic [PLANES-1:0] par_hit;
	logic [9:0] idx;
	logic wr_ok;
	logic [PLANES-1:0] par_w1c;

	// One register word written in this access
	function automatic logic wr_to(input logic ok, input logic [9:0] at, input logic [9:0] word);
		return ok && (at == word);
	endfunction

	assign idx = paddr[11:2];
	// Misaligned accesses are refused, so they must not write either
	assign wr_ok = psel && penable && pready && pwrite && (paddr[1:0] == 2'h0);
	assign par_w1c = wr_to(wr_ok, idx, REG_PAR_ERR) ? pwdata[PLANES-1:0] : '0;

	always_comb begin
		par_hit = '0;
		for (int i = 0; i < VLANES; i++) begin
			if (rx_par_rcvd[8*i +: 8] != rx_par_calc[8*i +: 8]) begin
				par_hit[i/(VLANES/PLANES)] = 1'b1;
			end
		end
		if (!rx_am_strobe) begin
			par_hit = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			lock_q <= '0;
		end else begin
			lock_q <= rx_cdr_lock;
		end
	end

	// Lane numbers past the last physical lane read as no flags, never unknown
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= 2'h0;
		end else if (int'(sel_q[3:0]) >= PLANES) begin
			flags_q <= 2'h0;
		end else if (sel_q[SEL_RX_BIT]) begin
			flags_q <= {rx_fifo_full[sel_q[3:0]], rx_fifo_empty[sel_q[3:0]]};
		end else begin
			flags_q <= {tx_fifo_full[sel_q[3:0]], tx_fifo_empty[sel_q[3:0]]};
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			err_cnt_q <= '0;
		end else if (clr_q) begin
			err_cnt_q <= '0;
		end else if (rx_ctrl_err && err_cnt_q != '1) begin
			err_cnt_q <= err_cnt_q + CNT_W'(1);
		end
	end

	// New parity hits win over a software clear in the same cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			par_err_q <= '0;
		end else begin
			par_err_q <= (par_err_q & ~par_w1c) | par_hit;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			clr_q <= 1'b0;
		end else if (wr_to(wr_ok, idx, REG_FRM_CLR)) begin
			clr_q <= pwdata[0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sel_q <= FLAG_SEL_RST;
		end else if (wr_to(wr_ok, idx, REG_FLAG_SEL)) begin
			sel_q <= pwdata[4:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			fault_en_q <= CTRL_FAULT_EN_RST;
		end else if (wr_to(wr_ok, idx, REG_LINK_CTRL)) begin
			fault_en_q <= pwdata[CTRL_FAULT_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state
	logic [31:0] rd;
	logic hit;

	always_comb begin
		rd = 32'h0;
		hit = (paddr[1:0] == 2'h0);
		unique case (idx)
			REG_CLK_LOCK: rd = 32'(lock_q);
			REG_FLAG_SEL: rd = 32'(sel_q);
			REG_FRAME_ERR: rd = 32'(err_cnt_q);
			REG_FRM_CLR: rd = 32'(clr_q);
			REG_FIFO_FLAGS: rd = 32'(flags_q);
			REG_ALIGN: rd = 32'(rx_align_ready);
			REG_LINK_CTRL: rd = 32'(fault_en_q);
			REG_LINK_STAT: rd = {30'h0, rx_digital_reset, local_fault};
			REG_PAR_ERR: rd = 32'(par_err_q);
			default: hit = 1'b0;
		endcase
		if (!hit) begin
			rd = 32'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			prdata <= pwrite ? 32'h0 : rd;
			pslverr <= !hit;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* epls_pkg.sv */
`default_nettype none
package epls_pkg;
	// Register word indices; byte address is four times the index
	localparam logic [9:0] REG_CLK_LOCK = 10'h321;
	localparam logic [9:0] REG_FLAG_SEL = 10'h322;
	localparam logic [9:0] REG_FRAME_ERR = 10'h323;
	localparam logic [9:0] REG_FRM_CLR = 10'h324;
	localparam logic [9:0] REG_FIFO_FLAGS = 10'h325;
	localparam logic [9:0] REG_ALIGN = 10'h326;
	localparam logic [9:0] REG_LINK_CTRL = 10'h327;
	localparam logic [9:0] REG_LINK_STAT = 10'h328;
	localparam logic [9:0] REG_PAR_ERR = 10'h329;
	// Field positions
	localparam int SEL_RX_BIT = 4;
	localparam int CTRL_FAULT_EN_BIT = 0;
	localparam logic CTRL_FAULT_EN_RST = 1'b0;
	localparam logic [4:0] FLAG_SEL_RST = 5'h00;
	// Line characters
	localparam logic [7:0] CH_IDLE = 8'h07;
	localparam logic [7:0] CH_START = 8'hfb;
	localparam logic [7:0] CH_TERM = 8'hfd;
	localparam logic [7:0] CH_ERR = 8'hfe;
	localparam logic [7:0] CH_PRE = 8'h55;
	localparam logic [7:0] CH_SFD = 8'hd5;
	// Framing figures
	localparam int PRE_BYTES = 7;
	localparam int FCS_BYTES = 4;
	localparam int IPG_BYTES = 12;
	localparam int IDLE_DEBT_MAX = 3;
	localparam int START_ALIGN = 8;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY_REFL = 32'hedb88320;
	// Timing
	localparam int CLK_MHZ = 25;
	localparam int RX_RST_NS = 1000;
	localparam int RX_RST_CYC = (RX_RST_NS * CLK_MHZ + 999) / 1000;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_PRE = 3'b001,
		TX_DATA = 3'b010,
		TX_FCS = 3'b011,
		TX_TERM = 3'b100
	} epls_tx_state_t;
endpackage
`default_nettype wire

/* epls_link_sva.sv */
`default_nettype none
module epls_link_sva import epls_pkg::*; (
	// Clock, reset and bus
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	// Streams and status
	input wire logic [7:0] tx_byte,
	input wire logic tx_is_ctrl,
	input wire logic rx_signal_ok,
	input wire logic rx_am_lock,
	input wire logic rx_align_ready,
	input wire logic local_fault,
	input wire logic rx_digital_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_am_drop; !rx_am_lock |=> !rx_align_ready; endproperty
	a_am_drop: assert property (p_am_drop) else $error("ready without marker lock");
	property p_sig_drop; !rx_signal_ok |=> !rx_align_ready; endproperty
	a_sig_drop: assert property (p_sig_drop) else $error("ready without signal");
	property p_fault; local_fault |-> !$past(rx_signal_ok); endproperty
	a_fault: assert property (p_fault) else $error("fault with signal present");
	property p_rst_go; $fell(rx_signal_ok) |=> rx_digital_reset; endproperty
	a_rst_go: assert property (p_rst_go) else $error("no rx reset on signal loss");
	property p_rst_hold; $rose(rx_digital_reset) |-> rx_digital_reset[*8]; endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("rx reset too short");
	property p_frame;
		tx_is_ctrl && tx_byte == CH_START |=> (!tx_is_ctrl && tx_byte == CH_PRE)[*6] ##1 tx_byte == CH_SFD;
	endproperty
	a_frame: assert property (p_frame) else $error("bad preamble");
	property p_gap; tx_is_ctrl && tx_byte == CH_TERM |=> (tx_is_ctrl && tx_byte == CH_IDLE)[*8]; endproperty
	a_gap: assert property (p_gap) else $error("gap too short");
	property p_apb; psel && penable && !pready |=> pready; endproperty
	a_apb: assert property (p_apb) else $error("bus answer late");
	c_fault: cover property (local_fault);
	c_rst: cover property ($rose(rx_digital_reset));
	c_start: cover property (tx_is_ctrl && tx_byte == CH_START);
endmodule
bind epls_link epls_link_sva chk_u (.sys_clk, .rstn, .psel, .penable, .pready, .tx_byte, .tx_is_ctrl,
	.rx_signal_ok, .rx_am_lock, .rx_align_ready, .local_fault, .rx_digital_reset);
`default_nettype wire

/* epls_partner.sv */
`default_nettype none
module epls_partner (
	// Bench control
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic link_on,
	input wire logic err_req,
	input wire logic [4:0] rot,
	input wire logic par_bad,
	// Lane side
	output logic rx_signal_ok,
	output logic rx_am_lock,
	output logic rx_ctrl_err,
	output logic rx_am_strobe,
	output logic [99:0] rx_lane_tag,
	output logic [159:0] rx_par_rcvd,
	output logic [159:0] rx_par_calc
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] am_q;
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{am_q, rx_signal_ok, rx_am_lock, rx_ctrl_err, rx_am_strobe} <= 8'h00;
		end else begin
			am_q <= am_q + 4'h1;
			rx_am_strobe <= (am_q == 4'hf);
			rx_signal_ok <= link_on;
			rx_am_lock <= link_on & rx_signal_ok;
			rx_ctrl_err <= err_req;
		end
	end
	// Remote lanes arrive skewed by rot; par_bad spoils the parity of lane 3
	always_comb begin
		for (int i = 0; i < 20; i++) begin
			rx_lane_tag[5*i+:5] = 5'((i + rot) % 20);
			rx_par_rcvd[8*i+:8] = 8'(i) ^ {7'h0, par_bad && i == 3};
			rx_par_calc[8*i+:8] = 8'(i);
		end
	end
endmodule
`default_nettype wire

/* epls_link_tb_top.sv */
`default_nettype none
module epls_link_tb_top import epls_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, tx_valid = 0, tx_last = 0;
	logic link_on = 1, err_req = 0, pready, pslverr, tx_ready, tx_is_ctrl, rx_signal_ok, rx_am_lock;
	logic rx_ctrl_err, rx_am_strobe, rx_align_ready, local_fault, rx_digital_reset, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [7:0] tx_data = 8'h00, tx_byte;
	logic [4:0] rot = 5'h00;
	logic par_bad = 0;
	logic [9:0] cdr = 10'h000, tff = 10'h000, tfe = 10'h000, rff = 10'h000, rfe = 10'h000;
	logic [99:0] rx_lane_tag, rx_lane_map;
	logic [159:0] rx_par_rcvd, rx_par_calc;
	int mismatches = 0, cmp_count = 0, cyc = 0;
	always #20 sys_clk = ~sys_clk;
	epls_link dut_u (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.tx_valid, .tx_data, .tx_last, .tx_ready, .tx_byte, .tx_is_ctrl, .rx_cdr_lock(cdr), .rx_signal_ok,
		.rx_am_lock, .rx_ctrl_err, .rx_am_strobe, .rx_lane_tag, .rx_par_rcvd, .rx_par_calc, .tx_fifo_full(tff),
		.tx_fifo_empty(tfe), .rx_fifo_full(rff), .rx_fifo_empty(rfe), .rx_align_ready, .local_fault,
		.rx_digital_reset, .rx_lane_map);
	epls_partner far_u (.sys_clk, .rstn, .link_on, .err_req, .rot, .par_bad, .rx_signal_ok, .rx_am_lock,
		.rx_ctrl_err, .rx_am_strobe, .rx_lane_tag, .rx_par_rcvd, .rx_par_calc);
	////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			complete_run;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// Idle edge after release keeps psel from being driven twice in one step
	// Waits for pready however long it takes; only the cycle ceiling ends a hang
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	task automatic rchk(input logic [9:0] idx, input logic [31:0] e, input string nm);
		apb(0, idx, 32'h0);
		chk(nm, e, rd);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		cdr <= 10'h2b5;
		rff <= 10'h008;
		tfe <= 10'h020;
		repeat (2) @(posedge sys_clk);
		rchk(REG_CLK_LOCK, 32'h2b5, "clk_lock");
		rchk(REG_ALIGN, 32'h1, "align");
		apb(1, REG_FLAG_SEL, 32'h13);
		rchk(REG_FIFO_FLAGS, 32'h2, "rx_flags");
		apb(1, REG_FLAG_SEL, 32'h05);
		rchk(REG_FIFO_FLAGS, 32'h1, "tx_flags");
		apb(0, 10'h3ff, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, er});
		$display("test regs done");
	endtask
	task automatic t_ferr;
		repeat (3) begin
			err_req <= 1;
			@(posedge sys_clk);
			err_req <= 0;
			@(posedge sys_clk);
		end
		repeat (2) @(posedge sys_clk);
		rchk(REG_FRAME_ERR, 32'h3, "frame_err_cnt");
		apb(1, REG_FRM_CLR, 32'h1);
		err_req <= 1;
		@(posedge sys_clk);
		err_req <= 0;
		apb(1, REG_FRM_CLR, 32'h0);
		rchk(REG_FRAME_ERR, 32'h0, "frame_err_clr");
		$display("test frame errors done");
	endtask
	// Two-byte payload: next byte offered on each accepted edge
	task automatic feed;
		if (tx_valid && tx_ready) begin
			if (tx_last) tx_valid <= 0;
			else begin
				tx_data <= 8'h3c;
				tx_last <= 1;
			end
		end
	endtask
	task automatic t_frame;
		logic [8:0] q[$];
		logic [7:0] pay[2] = '{8'ha5, 8'h3c};
		logic [31:0] c = CRC_INIT;
		q.push_back({1'b1, CH_START});
		repeat (6) q.push_back({1'b0, CH_PRE});
		q.push_back({1'b0, CH_SFD});
		for (int j = 0; j < 2; j++) begin
			q.push_back({1'b0, pay[j]});
			c ^= {24'h0, pay[j]};
			for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
		end
		c = ~c;
		for (int j = 0; j < 4; j++) q.push_back({1'b0, c[8*j+:8]});
		q.push_back({1'b1, CH_TERM});
		tx_data <= 8'ha5;
		tx_last <= 0;
		tx_valid <= 1;
		do begin
			@(posedge sys_clk);
			feed;
		end while (!(tx_is_ctrl === 1'b1 && tx_byte === CH_START));
		for (int i = 0; i < 15; i++) begin
			chk("tx_byte", {23'h0, q[i]}, {23'h0, tx_is_ctrl, tx_byte});
			chk("tx_ready", {31'h0, i == 7 || i == 8}, {31'h0, tx_ready});
			@(posedge sys_clk);
			feed;
		end
		$display("test frame done");
	endtask
	task automatic t_lanes;
		rot <= 5'd5;
		par_bad <= 1;
		// Partner marks every 16 cycles, so two and a half marker periods
		repeat (40) @(posedge sys_clk);
		par_bad <= 0;
		for (int t = 0; t < 20; t++) chk("lane_map", 32'((t + 15) % 20), {27'h0, rx_lane_map[5*t+:5]});
		// Virtual lane 3 rides physical lane 1
		rchk(REG_PAR_ERR, 32'h2, "par_err");
		apb(1, REG_PAR_ERR, 32'h2);
		rchk(REG_PAR_ERR, 32'h0, "par_err_clr");
		$display("test lanes done");
	endtask
	task automatic t_los;
		apb(1, REG_LINK_CTRL, 32'h1);
		link_on <= 0;
		repeat (4) @(posedge sys_clk);
		chk("align_ready", 32'h0, {31'h0, rx_align_ready});
		chk("local_fault", 32'h1, {31'h0, local_fault});
		chk("rx_reset", 32'h1, {31'h0, rx_digital_reset});
		rchk(REG_LINK_STAT, 32'h3, "link_stat");
		rchk(REG_ALIGN, 32'h0, "align_reg");
		t_frame;
		link_on <= 1;
		$display("test signal loss done");
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1;
		@(posedge sys_clk);
		t_regs;
		t_ferr;
		t_lanes;
		t_los;
		complete_run;
	end
endmodule
`default_nettype wire
